/* File: rtl/ubc_break_ctrl.sv */
// Break control register, match flags and break issue of the break unit.
//
// Decided for this implementation: the APB register port and the register addresses.
`include "ubc_regs.svh"
module ubc_break_ctrl #(
  parameter int ASID_W = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire ubc_pkg::ubc_cycle_type cpu_cyc_a,
  input  wire ubc_pkg::ubc_cycle_type cpu_cyc_b,
  input  wire ubc_pkg::ubc_cycle_type dma_cyc_a,
  input  wire ubc_pkg::ubc_cycle_type dma_cyc_b,
  input  wire logic [7:0]         break_asid_chan_a,
  input  wire logic [7:0]         break_asid_chan_b,
  output logic                    user_break,
  output logic                    break_after_exec,
  output logic                    pc_trace_enable,
  output logic                    irq
);
  import ubc_pkg::*;

  initial
  begin
    if (ASID_W != 8)
    begin
      $error("ASID width must be 8.");
    end
  end

  // ****************************************************************
  // Condition evaluation
  // ****************************************************************
  logic [31:0]              ctrl_ff;
  logic [`UBC_COUNT_W-1:0]  exec_count_remaining_ff;
  ubc_seq_type              seq_ff;
  logic [1:0]               irq_stat_ff;
  logic [1:0]               irq_mask_ff;
  logic                     user_break_ff;
  logic                     after_ff;
  logic [31:0]              prdata_ff;

  logic asid_mask_chan_a;
  logic asid_mask_chan_b;
  logic data_compare_enable_b;
  logic sequential_select;
  logic exec_count_break_enable;
  assign asid_mask_chan_a        = ctrl_ff[`UBC_BIT_ASM_A];
  assign asid_mask_chan_b        = ctrl_ff[`UBC_BIT_ASM_B];
  assign data_compare_enable_b   = ctrl_ff[`UBC_BIT_DBE_B];
  assign sequential_select       = ctrl_ff[`UBC_BIT_SEQ];
  assign exec_count_break_enable = ctrl_ff[`UBC_BIT_EXEC_COUNT_BREAK_ENABLE];

  function automatic logic hit_a(input ubc_cycle_type c,
                                 input logic [7:0] asid,
                                 input logic mask);
    hit_a = c.valid && c.addr_hit && (mask || c.asid == asid);
  endfunction

  ubc_chan_type cpu_hit;
  ubc_chan_type dma_hit;
  logic         hit_any_a;
  logic         hit_any_b;
  logic         fetch_b;
  always_comb
  begin
    cpu_hit.a = hit_a(cpu_cyc_a, break_asid_chan_a, asid_mask_chan_a);
    dma_hit.a = hit_a(dma_cyc_a, break_asid_chan_a, asid_mask_chan_a);
    cpu_hit.b = hit_a(cpu_cyc_b, break_asid_chan_b, asid_mask_chan_b)
                && (!data_compare_enable_b || cpu_cyc_b.data_hit);
    dma_hit.b = hit_a(dma_cyc_b, break_asid_chan_b, asid_mask_chan_b)
                && (!data_compare_enable_b || dma_cyc_b.data_hit);
    hit_any_a = cpu_hit.a || dma_hit.a;
    hit_any_b = cpu_hit.b || dma_hit.b;
    fetch_b   = (cpu_hit.b && cpu_cyc_b.is_fetch)
                || (dma_hit.b && dma_cyc_b.is_fetch);
  end

  // ****************************************************************
  // Register bus and control state
  // ****************************************************************
  // The slave answers in the access cycle itself, so pready is constant.
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = paddr == `UBC_CTRL_OFFSET || paddr == `UBC_COUNT_OFFSET
                   || paddr == `UBC_IRQ_STAT_OFF
                   || paddr == `UBC_IRQ_MASK_OFF;

  logic [31:0]             nxt_ctrl;
  logic [`UBC_COUNT_W-1:0] nxt_count;
  ubc_seq_type             nxt_seq;
  logic [1:0]              nxt_irq_stat;
  logic [1:0]              nxt_irq_mask;
  logic                    nxt_user_break;
  logic                    nxt_after;
  logic [31:0]             nxt_prdata;
  logic                    b_qualifies;
  logic                    brk_a;
  logic                    brk_b;
  logic [3:0]              flag_set;
  logic [3:0]              flag_keep;

  always_comb
  begin
    nxt_ctrl     = ctrl_ff;
    nxt_count    = exec_count_remaining_ff;
    nxt_seq      = seq_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_prdata   = prdata_ff;
    if (wr_en && paddr == `UBC_CTRL_OFFSET)
    begin
      // Unused bits never store, so they read back as zero.
      nxt_ctrl = pwdata & `UBC_CTRL_RW_MASK;
      // A written one keeps the flag; only zero clears.
      flag_keep = ctrl_ff[15:12] & pwdata[15:12];
      nxt_ctrl[15:12] = flag_keep;
    end
    else
    begin
      flag_keep = ctrl_ff[15:12];
    end
    flag_set = {cpu_hit.a, cpu_hit.b, dma_hit.a, dma_hit.b};
    // Hardware set wins over a software clear in the same cycle.
    nxt_ctrl[15:12] = flag_keep | flag_set;

    // Sequential mode: B counts only once A has been seen.
    b_qualifies = hit_any_b
                  && (!sequential_select || seq_ff == UBC_SEQ_ARMED);
    brk_a = hit_any_a && !sequential_select;
    brk_b = b_qualifies;
    if (sequential_select && hit_any_a)
    begin
      nxt_seq = UBC_SEQ_ARMED;
    end
    if (b_qualifies)
    begin
      nxt_seq = UBC_SEQ_IDLE;
    end
    if (!sequential_select)
    begin
      nxt_seq = UBC_SEQ_IDLE;
    end
    if (b_qualifies && exec_count_break_enable)
    begin
      // Break only on the match that finds the count already at one.
      brk_b = exec_count_remaining_ff == `UBC_COUNT_W'(1);
      if (exec_count_remaining_ff > `UBC_COUNT_W'(1))
      begin
        nxt_count = exec_count_remaining_ff - `UBC_COUNT_W'(1);
      end
    end
    if (wr_en && paddr == `UBC_COUNT_OFFSET)
    begin
      nxt_count = pwdata[`UBC_COUNT_W-1:0];
    end
    if (wr_en && paddr == `UBC_IRQ_MASK_OFF)
    begin
      nxt_irq_mask = pwdata[1:0];
    end
    nxt_irq_stat = irq_stat_ff;
    if (wr_en && paddr == `UBC_IRQ_STAT_OFF)
    begin
      nxt_irq_stat = irq_stat_ff & ~pwdata[1:0];
    end
    nxt_irq_stat = nxt_irq_stat | {brk_b, brk_a};
    nxt_user_break = brk_a || brk_b;
    // A channel B break uses the B bit on fetches, else before; a break on channel A alone uses the A bit.
    nxt_after = brk_b ? (fetch_b && ctrl_ff[`UBC_BIT_AFT_B])
                      : ctrl_ff[`UBC_BIT_AFT_A];
    if (!nxt_user_break)
    begin
      nxt_after = 1'b0;
    end
    if (rd_en)
    begin
      case (paddr)
        `UBC_CTRL_OFFSET:  nxt_prdata = ctrl_ff & `UBC_CTRL_RW_MASK;
        `UBC_COUNT_OFFSET: nxt_prdata = {20'h0_0000, exec_count_remaining_ff};
        `UBC_IRQ_STAT_OFF: nxt_prdata = {30'h0, irq_stat_ff};
        `UBC_IRQ_MASK_OFF: nxt_prdata = {30'h0, irq_mask_ff};
        default:           nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff                 <= `UBC_CTRL_RESET;
      exec_count_remaining_ff <= '0;
      seq_ff                  <= UBC_SEQ_IDLE;
      irq_stat_ff             <= 2'h0;
      irq_mask_ff             <= 2'h0;
      user_break_ff           <= 1'b0;
      after_ff                <= 1'b0;
      prdata_ff               <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff                 <= nxt_ctrl;
      exec_count_remaining_ff <= nxt_count;
      seq_ff                  <= nxt_seq;
      irq_stat_ff             <= nxt_irq_stat;
      irq_mask_ff             <= nxt_irq_mask;
      user_break_ff           <= nxt_user_break;
      after_ff                <= nxt_after;
      prdata_ff               <= nxt_prdata;
    end
  end

  logic irq_ff;
  logic slverr_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ff    <= 1'b0;
      slverr_ff <= 1'b0;
    end
    else
    begin
      irq_ff    <= |(nxt_irq_stat & nxt_irq_mask);
      slverr_ff <= psel && !penable && !addr_ok;
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = 1'b1;
  assign pslverr          = slverr_ff;
  assign user_break       = user_break_ff;
  assign break_after_exec = after_ff;
  assign pc_trace_enable  = ctrl_ff[`UBC_BIT_PC_TRACE_ENABLE];
  assign irq              = irq_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flag_set_cpu_a: assert property (cpu_hit.a |=> ctrl_ff[15])
    else $error("CPU channel A flag not set.");
  flag_set_dma_b: assert property (dma_hit.b |=> ctrl_ff[12])
    else $error("DMA channel B flag not set.");
  flag_sticky_a: assert property ($fell(ctrl_ff[14]) |->
      $past(wr_en && paddr == `UBC_CTRL_OFFSET && !pwdata[14]))
    else $error("Flag cleared without a zero write.");
  flag_no_set_a: assert property ($rose(ctrl_ff[13]) |-> $past(dma_hit.a))
    else $error("Flag set without a match.");
  reserved_zero_a: assert property ((ctrl_ff & ~`UBC_CTRL_RW_MASK) == 0)
    else $error("Reserved control bits not zero.");
  seq_a_alone_a: assert property (sequential_select && !hit_any_b
                                  |=> !user_break)
    else $error("Sequential break without channel B.");
  count_dec_a: assert property (b_qualifies && exec_count_break_enable
      && exec_count_remaining_ff > 1 && !wr_en
      |=> exec_count_remaining_ff == $past(exec_count_remaining_ff) - 1)
    else $error("Count did not decrement.");
  asid_mask_a: assert property (cpu_cyc_a.valid && cpu_cyc_a.addr_hit
      && asid_mask_chan_a && !sequential_select |=> user_break)
    else $error("Masked ASID blocked channel A.");
  trace_a: assert property (wr_en && paddr == `UBC_CTRL_OFFSET
      |=> pc_trace_enable == $past(pwdata[11]))
    else $error("Trace enable mismatch.");

  // ****************************************************************
  // Further checks on flags, sequencing and the bus
  // ****************************************************************
  // A zero write must clear the flag when no hardware match races it.
  flag_clear_a: assert property (wr_en && paddr == `UBC_CTRL_OFFSET
      && !pwdata[15] && !cpu_hit.a |=> !ctrl_ff[15])
    else $error("Zero write did not clear the flag.");
  flag_keep_a: assert property (ctrl_ff[12]
      && !(wr_en && paddr == `UBC_CTRL_OFFSET && !pwdata[12]) |=> ctrl_ff[12])
    else $error("Flag lost without a zero write.");
  seq_break_a: assert property (sequential_select
      && seq_ff == UBC_SEQ_ARMED && hit_any_b && !exec_count_break_enable
      |=> user_break)
    else $error("Armed sequence did not break on channel B.");
  count_break_a: assert property (b_qualifies && exec_count_break_enable
      && exec_count_remaining_ff == `UBC_COUNT_W'(1) |=> user_break)
    else $error("Count break missing.");
  count_zero_a: assert property (exec_count_break_enable
      && exec_count_remaining_ff == '0 && !hit_any_a |=> !user_break)
    else $error("Break issued with a zero count.");
  unused_read_a: assert property (rd_en && paddr == `UBC_CTRL_OFFSET
      |=> (prdata & ~`UBC_CTRL_RW_MASK) == 0)
    else $error("Unused control bits read as one.");
  data_gate_b: assert property (data_compare_enable_b && cpu_cyc_b.valid
      && !cpu_cyc_b.data_hit |-> !cpu_hit.b)
    else $error("Channel B matched without a data match.");
  asid_check_b: assert property (!asid_mask_chan_b
      && dma_cyc_b.asid != break_asid_chan_b |-> !dma_hit.b)
    else $error("Channel B matched with a wrong ASID.");
  irq_level_a: assert property (irq == |(irq_stat_ff & irq_mask_ff))
    else $error("Interrupt level does not follow status and mask.");
  after_idle_a: assert property (!user_break |-> !break_after_exec)
    else $error("After-execution flag without a break.");
  slverr_map_a: assert property (psel && !penable && !addr_ok |=> pslverr)
    else $error("Unmapped access without an error.");
  prdata_hold_a: assert property (!rd_en |=> $stable(prdata))
    else $error("Read data changed without a read.");
  stat_set_a: assert property (user_break |-> irq_stat_ff != 2'h0)
    else $error("Break did not set interrupt status.");
  cov_seq: cover property (sequential_select && seq_ff == UBC_SEQ_ARMED
                           && hit_any_b);
  cov_count: cover property (exec_count_break_enable && brk_b);
  cov_clear: cover property ($fell(ctrl_ff[15]));
  cov_after: cover property (user_break && break_after_exec);
endmodule

/* File: rtl/ubc_regs.svh */
// Offsets, field positions, reset values and count width of the break unit.
// ****************************************************************
// What this block does
// - Power-on reset clears the whole break control register to zero.
// - Unused bits 31-22, 19-16, 9-8, 5-4, 2-1 read as zero.
// - Channel A ASID mask zero compares ASID; one ignores ASID.
// - Channel B ASID mask zero compares ASID; one ignores ASID.
// - Match flags are set by hardware, cleared only by writing zero.
// - Bit 15 sets on a processor cycle matching channel A.
// - Bit 14 sets on a processor cycle matching channel B.
// - Bit 13 sets on a DMA cycle matching channel A.
// - Bit 12 sets on a DMA cycle matching channel B.
// - Bit 11 enables program counter tracing; zero disables it.
// - Bit 10 picks before or after execution for any channel A break without a channel B break.
// - Bit 7 adds the data bus match to channel B's condition.
// - Bit 6 picks before or after execution for channel B fetch.
// - Bit 3 selects independent or sequential A-then-B evaluation.
// - Bit 0 enables execution-count break on channel B only.
// - Each qualifying channel B match (after A in sequential mode) decrements a count above one; break when count is one.
// ****************************************************************
`ifndef UBC_REGS_SVH
`define UBC_REGS_SVH
`define UBC_CTRL_OFFSET   12'h000
`define UBC_COUNT_OFFSET  12'h004
`define UBC_IRQ_STAT_OFF  12'h008
`define UBC_IRQ_MASK_OFF  12'h00c
`define UBC_CTRL_RESET    32'h0000_0000
`define UBC_CTRL_RW_MASK  32'h0030_fcc9
`define UBC_BIT_ASM_A     21
`define UBC_BIT_ASM_B     20
`define UBC_BIT_FCA       15
`define UBC_BIT_FCB       14
`define UBC_BIT_FDA       13
`define UBC_BIT_FDB       12
`define UBC_BIT_PC_TRACE_ENABLE      11
`define UBC_BIT_AFT_A     10
`define UBC_BIT_DBE_B     7
`define UBC_BIT_AFT_B     6
`define UBC_BIT_SEQ       3
`define UBC_BIT_EXEC_COUNT_BREAK_ENABLE      0
`define UBC_COUNT_W       12
`endif

/* File: rtl/ubc_pkg.sv */
// Types shared by the break control register logic.
package ubc_pkg;
  typedef struct packed {
    logic       valid;
    logic       is_fetch;
    logic [7:0] asid;
    logic       addr_hit;
    logic       data_hit;
  } ubc_cycle_type;
  typedef struct packed {
    logic a;
    logic b;
  } ubc_chan_type;
  typedef enum logic [0:0] {
    UBC_SEQ_IDLE  = 1'b0,
    UBC_SEQ_ARMED = 1'b1
  } ubc_seq_type;
endpackage

/* File: dv/ubc_bus_partner.sv */
// Model of the processor and DMA bus comparators feeding the break unit.
module ubc_bus_partner (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [3:0]             req,
  input  wire ubc_pkg::ubc_cycle_type req_cyc,
  output ubc_pkg::ubc_cycle_type      cpu_a,
  output ubc_pkg::ubc_cycle_type      cpu_b,
  output ubc_pkg::ubc_cycle_type      dma_a,
  output ubc_pkg::ubc_cycle_type      dma_b
);
  timeunit 1ns;
  timeprecision 1ps;
  import ubc_pkg::*;
  logic          tgl_ff = 1'b0;
  ubc_cycle_type idle;
  // Idle fields other than valid keep changing; valid stays zero so none is a cycle.
  assign idle = {1'b0, {11{tgl_ff}}};
  always_ff @(posedge pclk)
  begin
    tgl_ff <= ~tgl_ff;
    cpu_a  <= (req[0] && presetn) ? req_cyc : idle;
    cpu_b  <= (req[1] && presetn) ? req_cyc : idle;
    dma_a  <= (req[2] && presetn) ? req_cyc : idle;
    dma_b  <= (req[3] && presetn) ? req_cyc : idle;
  end
endmodule

/* File: dv/ubc_break_ctrl_tb.sv */
// Self-checking bench of the break control register logic.
`include "ubc_regs.svh"
module ubc_break_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ubc_pkg::*;
  localparam logic [11:0] CT = `UBC_CTRL_OFFSET;
  localparam logic [11:0] CN = `UBC_COUNT_OFFSET;
  localparam logic [11:0] ST = `UBC_IRQ_STAT_OFF;
  localparam logic [11:0] MK = `UBC_IRQ_MASK_OFF;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, user_break, bae, trace, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [7:0] asid_a = '0, asid_b = '0, ra, rb;
  logic [3:0] req = '0;
  logic err, last_bae = 1'b0;
  ubc_cycle_type req_cyc = '0, ca, cb, da, db;
  int seed = 54674, n_tests = 0, n_mismatch = 0, n_brk = 0, b0;
  always #2 pclk = ~pclk;
  ubc_bus_partner ubc_bus_partner_i (.pclk(pclk), .presetn(presetn),
    .req(req), .req_cyc(req_cyc), .cpu_a(ca), .cpu_b(cb), .dma_a(da),
    .dma_b(db));
  ubc_break_ctrl ubc_break_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_cyc_a(ca), .cpu_cyc_b(cb), .dma_cyc_a(da), .dma_cyc_b(db),
    .break_asid_chan_a(asid_a), .break_asid_chan_b(asid_b),
    .user_break(user_break), .break_after_exec(bae),
    .pc_trace_enable(trace), .irq(irq));
  always @(posedge pclk)
  begin
    if (user_break === 1'b1)
    begin
      n_brk <= n_brk + 1;
      last_bae <= bae;
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Answer is sampled in the access cycle, so it is the value at the edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    q = prdata;
    err = pslverr;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic send(input int k, input logic f, input logic [7:0] s,
                      input logic dh);
    req <= 4'h1 << k;
    req_cyc <= {1'b1, f, s, 1'b1, dh};
    @(posedge pclk);
    req <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask
  function automatic logic hit(int k, logic [7:0] s, logic [31:0] c,
                               logic dh);
    logic b;
    b = k[0];
    hit = ((b ? c[20] : c[21]) | (s == (b ? asid_b : asid_a)))
          & (!b | !c[7] | dh);
  endfunction
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    int k;
    logic [31:0] c, e;
    logic [7:0] s;
    logic dh;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CT, 32'h0, "ctrl reset");
    apb(1'b1, CT, 32'h0030_fcc9);
    rdc(CT, 32'h0030_0cc9, "ctrl rw");
    $display("test registers done");
    for (int n = 0; n < 32; n++)
    begin
      k = n % 4;
      ra = $random(seed);
      rb = $random(seed);
      asid_a <= ra;
      asid_b <= rb;
      c = $random(seed) & 32'h0030_0080;
      apb(1'b1, CT, c);
      s = $random(seed);
      if (n[2])
        s = k[0] ? rb : ra;
      dh = $random(seed);
      send(k, 1'b0, s, dh);
      e = c | (32'(hit(k, s, c, dh)) << (15 - k));
      rdc(CT, e, "flag set");
      apb(1'b1, CT, e | 32'h0000_f000);
      rdc(CT, e, "flag sticky");
    end
    $display("test flags done");
    for (int j = 0; j < 4; j++)
    begin
      apb(1'b1, CT, j[1] ? 32'h0000_0840 : 32'h0000_0c00);
      @(posedge pclk);
      chk("trace", trace, 1'b1);
      b0 = n_brk;
      send(j[0], 1'b1, j[0] ? rb : ra, 1'b1);
      chk("brk indep", n_brk - b0, 1);
      chk("after exec", last_bae, j[0] == j[1]);
    end
    $display("test timing done");
    apb(1'b1, CT, 32'h0000_0008);
    b0 = n_brk;
    send(1, 1'b0, rb, 1'b0);
    send(0, 1'b0, ra, 1'b0);
    chk("seq early", n_brk - b0, 0);
    send(1, 1'b0, rb, 1'b0);
    chk("seq brk", n_brk - b0, 1);
    $display("test sequence done");
    apb(1'b1, CN, 32'h3);
    apb(1'b1, CT, 32'h0000_0001);
    b0 = n_brk;
    for (int i = 0; i < 3; i++)
    begin
      send(3, 1'b0, rb, 1'b0);
      rdc(CN, i < 2 ? 2 - i : 1, "count");
      chk("count brk", n_brk - b0, i == 2);
    end
    $display("test count done");
    apb(1'b1, MK, 32'h0);
    rdc(ST, 32'h3, "irq stat");
    repeat (2) @(posedge pclk);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, MK, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq on", irq, 1'b1);
    apb(1'b1, ST, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq clear", irq, 1'b0);
    rdc(ST, 32'h1, "irq w1c");
    rdc(12'h010, 32'h0, "unmapped");
    chk("slverr", err, 1'b1);
    $display("test interrupt done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("trace reset", trace, 1'b0);
    chk("irq reset", irq, 1'b0);
    rdc(CT, 32'h0, "ctrl rereset");
    $display("test reset done");
    complete_run();
  end
endmodule
